// File: rtl/sdpci_pkg.sv
package sdpci_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 12;
  localparam int COL_W      = 8;
  localparam int BANK_W     = 2;
  localparam int DATA_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int LANES      = 2;
  localparam int AP_BIT     = 10;
  localparam int RD_MASK_LAT = 2;
  localparam int BURST_LEN  = 4;
  localparam int MODEL_ROWS = 16;
  localparam int ROW_IDX_W  = 4;

  localparam logic [BANK_W-1:0] BANK_NONE_ALL = 2'h0;

  // ----------------------------------------------------------------
  // Command encoding {row strobe, column strobe, write strobe}
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDPCI_CMD_MODE  = 3'h0,
    SDPCI_CMD_REF   = 3'h1,
    SDPCI_CMD_PRE   = 3'h2,
    SDPCI_CMD_ACT   = 3'h3,
    SDPCI_CMD_WR    = 3'h4,
    SDPCI_CMD_RD    = 3'h5,
    SDPCI_CMD_BST   = 3'h6,
    SDPCI_CMD_NOP   = 3'h7
  } sdpci_cmd_e;

  typedef enum logic [1:0] {
    SDPCI_ST_IDLE  = 2'h0,
    SDPCI_ST_READ  = 2'h1,
    SDPCI_ST_WRITE = 2'h2
  } sdpci_st_e;

  // Power state: run while the clock gate is high, a low-power state while it is low
  typedef enum logic [1:0] {
    SDPCI_PW_RUN     = 2'h0,
    SDPCI_PW_DOWN    = 2'h1,
    SDPCI_PW_SUSPEND = 2'h2,
    SDPCI_PW_SELFREF = 2'h3
  } sdpci_pw_e;

  typedef struct packed {
    logic                  chip_select_n;
    logic                  row_strobe_n;
    logic                  col_strobe_n;
    logic                  write_strobe_n;
    logic [BANK_W-1:0]     bank_select_lines;
    logic [ADDR_W-1:0]     row_column_addr_lines;
  } sdpci_cmd_s;

  typedef struct packed {
    logic [BANK_W-1:0]     bank;
    logic [ROW_IDX_W-1:0]  row;
    logic [COL_W-1:0]      col;
    logic [DATA_W-1:0]     data;
    logic [LANES-1:0]      mask;
  } sdpci_wr_s;

  localparam int WR_S_W = $bits(sdpci_wr_s);

endpackage : sdpci_pkg

// File: rtl/sdpci_top.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Write buffer FIFO
// ------------------------------------------------------------------
module sdpci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin
      $error("sdpci_fifo: DEPTH must be a power of two");
    end
    if (WIDTH < 1) begin
      $error("sdpci_fifo: WIDTH must be at least one");
    end
  end

  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
  } sdpci_fifo_s;

  sdpci_fifo_s      st_r;
  sdpci_fifo_s      st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  assign full      = (st_r.wp[PW] != st_r.rp[PW]) &&
                     (st_r.wp[PW-1:0] == st_r.rp[PW-1:0]);
  assign empty     = (st_r.wp == st_r.rp);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[st_r.rp[PW-1:0]];

  // ----------------------------------------------------------------
  // Pointer update
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (in_valid && !full) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (in_valid && !full) begin
      mem[st_r.wp[PW-1:0]] <= in_data;
    end
  end
endmodule : sdpci_fifo

// ------------------------------------------------------------------
// Device pin command interface
// ------------------------------------------------------------------
// Summary of operation
// - Activate captures all twelve address lines as row for the bank.
// - Read or write takes starting column from address bits 0..7.
// - Address bit 10 on read or write requests auto precharge.
// - Precharge: bit 10 high closes all banks, low only selected bank.
// - Mode load takes the mode opcode from the address lines.
// - Bank select lines name the bank each bank command applies to.
// - An edge counts only when the clock gate is high.
// - Clock gate low means power-down, clock suspend or self refresh.
// - Clock gate sampled on the same rising edge as the other inputs.
// - Chip select must be low for a command to be accepted.
// - Chip select high keeps state and running operation unchanged.
// - Low mask governs data bits 0..7, high mask bits 8..15.
// - On reads a masked lane is undriven, unmasked lane driven.
// - On writes a masked lane is discarded, location unchanged.
// - Command decoded from three strobes sampled on one valid edge.
// - Read mask acts two clocks after it is registered.
// - Write mask acts on the same edge as the data word.
module sdpci_top
  import sdpci_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              clock_gate,
  input  wire sdpci_cmd_s        cmd_in,
  input  wire logic [LANES-1:0]  byte_mask,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic      [DATA_W-1:0] data_lines_out,
  output logic      [LANES-1:0]  data_lines_oe_n,
  output logic      [BANK_W-1:0] open_banks_0,
  output logic      [ADDR_W-1:0] mode_reg,
  output sdpci_pw_e              power_state,
  output logic                   buf_stall
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int BANKS = 1 << BANK_W;

  initial begin
    if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin
      $error("sdpci_top: FIFO_DEPTH must be a power of two");
    end
    if (BURST_LEN < 1 || BURST_LEN > 7) begin
      $error("sdpci_top: BURST_LEN does not fit the beat counter");
    end
    if (RD_MASK_LAT < 2) begin
      $error("sdpci_top: RD_MASK_LAT below two is not served");
    end
    if (ROW_IDX_W > ADDR_W || COL_W > ADDR_W || AP_BIT >= ADDR_W) begin
      $error("sdpci_top: address fields exceed the address lines");
    end
    if (LANES * BYTE_W != DATA_W) begin
      $error("sdpci_top: byte lanes do not cover the data lines");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  typedef struct packed {
    logic [BANKS-1:0]             open;
    logic [BANKS-1:0][ADDR_W-1:0] row;
    logic [ADDR_W-1:0]            mode;
    sdpci_st_e                    st;
    logic [BANK_W-1:0]            bank;
    logic [COL_W-1:0]             col;
    logic                         ap;
    logic [2:0]                   beats;
    logic [RD_MASK_LAT-1:0][LANES-1:0] mask_pipe;
    logic [RD_MASK_LAT-1:0]       rd_pipe;
    logic [RD_MASK_LAT-1:0][DATA_W-1:0] dout_pipe;
    logic [DATA_W-1:0]            dout;
    logic [LANES-1:0]             oe_n;
    sdpci_pw_e                    pw;
    logic                         stall;
    logic                         gate_q;
  } sdpci_state_s;

  sdpci_state_s st_r;
  sdpci_state_s st_nxt;

  // Small storage array, rows folded into a model window
  logic [DATA_W-1:0] mem [BANKS*MODEL_ROWS*(1<<COL_W)];

  sdpci_cmd_e  cmd;
  logic        cmd_ok;
  logic        wr_beat;
  sdpci_wr_s   wr_word;
  sdpci_wr_s   wr_out;
  logic        wr_valid;
  logic        wr_ready;
  logic        drain_ok;
  logic [BANK_W+ROW_IDX_W+COL_W-1:0] rd_idx;
  logic [BANK_W+ROW_IDX_W+COL_W-1:0] wr_idx;
  logic [DATA_W-1:0] rd_word;
  logic              burst_last;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign cmd    = sdpci_cmd_e'({cmd_in.row_strobe_n, cmd_in.col_strobe_n,
                                cmd_in.write_strobe_n});
  assign cmd_ok = clock_gate && !cmd_in.chip_select_n;
  assign wr_beat = clock_gate && (st_r.st == SDPCI_ST_WRITE);
  assign burst_last = (st_r.beats == 3'h1);

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------

  assign wr_word.bank = st_r.bank;
  assign wr_word.row  = st_r.row[st_r.bank][ROW_IDX_W-1:0];
  assign wr_word.col  = st_r.col;
  assign wr_word.data = data_lines_in;
  assign wr_word.mask = byte_mask;

  assign rd_idx  = {st_r.bank, st_r.row[st_r.bank][ROW_IDX_W-1:0],
                    st_r.col};
  assign rd_word = mem[rd_idx];
  assign wr_idx  = {wr_out.bank, wr_out.row, wr_out.col};
  assign drain_ok = clock_gate;

  sdpci_fifo #(
    .WIDTH (WR_S_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (wr_beat),
    .in_ready  (wr_ready),
    .in_data   (wr_word),
    .out_valid (wr_valid),
    .out_ready (drain_ok),
    .out_data  (wr_out)
  );

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (wr_valid && drain_ok) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wr_out.mask[l]) begin
          mem[wr_idx][l*BYTE_W +: BYTE_W] <=
            wr_out.data[l*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.gate_q = clock_gate;
    st_nxt.stall  = !wr_ready;
    if (!clock_gate) begin
      if (st_r.pw == SDPCI_PW_RUN) begin
        if (st_r.st != SDPCI_ST_IDLE) begin
          st_nxt.pw = SDPCI_PW_SUSPEND;
        end else if (st_r.gate_q && !cmd_in.chip_select_n &&
                     cmd == SDPCI_CMD_REF) begin
          st_nxt.pw = SDPCI_PW_SELFREF;
        end else begin
          st_nxt.pw = SDPCI_PW_DOWN;
        end
      end
    end else begin
      st_nxt.pw = SDPCI_PW_RUN;
      // Mask, data and valid travel together so lanes line up
      st_nxt.mask_pipe = {st_r.mask_pipe[RD_MASK_LAT-2:0],
                          byte_mask};
      st_nxt.dout_pipe = {st_r.dout_pipe[RD_MASK_LAT-2:0], rd_word};
      st_nxt.rd_pipe   = {st_r.rd_pipe[RD_MASK_LAT-2:0], 1'b0};
      st_nxt.oe_n      = '1;
      if (st_r.rd_pipe[RD_MASK_LAT-1]) begin
        st_nxt.dout = st_r.dout_pipe[RD_MASK_LAT-1];
        st_nxt.oe_n = st_r.mask_pipe[RD_MASK_LAT-1];
      end
      if (st_r.st != SDPCI_ST_IDLE) begin
        if (st_r.st == SDPCI_ST_READ) begin
          st_nxt.rd_pipe[0] = 1'b1;
        end
        st_nxt.col   = st_r.col + 1'b1;
        st_nxt.beats = st_r.beats - 1'b1;
        if (burst_last) begin
          st_nxt.st = SDPCI_ST_IDLE;
          if (st_r.ap) begin
            st_nxt.open[st_r.bank] = 1'b0;
          end
        end
      end
      if (cmd_ok) begin
        unique case (cmd)
          SDPCI_CMD_ACT: begin
            st_nxt.open[cmd_in.bank_select_lines] = 1'b1;
            st_nxt.row[cmd_in.bank_select_lines] =
              cmd_in.row_column_addr_lines;
          end
          SDPCI_CMD_RD, SDPCI_CMD_WR: begin
            st_nxt.st    = (cmd == SDPCI_CMD_RD) ? SDPCI_ST_READ
                                                 : SDPCI_ST_WRITE;
            st_nxt.bank  = cmd_in.bank_select_lines;
            st_nxt.col   = cmd_in.row_column_addr_lines[COL_W-1:0];
            st_nxt.ap    = cmd_in.row_column_addr_lines[AP_BIT];
            st_nxt.beats = 3'(BURST_LEN);
          end
          SDPCI_CMD_PRE: begin
            if (cmd_in.row_column_addr_lines[AP_BIT]) begin
              st_nxt.open = '0;
            end else begin
              st_nxt.open[cmd_in.bank_select_lines] = 1'b0;
            end
          end
          SDPCI_CMD_MODE: begin
            st_nxt.mode = cmd_in.row_column_addr_lines;
          end
          SDPCI_CMD_BST: begin
            st_nxt.st = SDPCI_ST_IDLE;
          end
          SDPCI_CMD_REF, SDPCI_CMD_NOP: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r      <= '0;
      st_r.oe_n <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_lines_out  = st_r.dout;
  assign data_lines_oe_n = st_r.oe_n;
  assign open_banks_0    = {st_r.open[1], st_r.open[0]};
  assign mode_reg        = st_r.mode;
  assign power_state     = st_r.pw;
  assign buf_stall       = st_r.stall;
endmodule : sdpci_top

// File: tb/sdpci_top_props.sv
`timescale 1ns/1ps
// ----------
// Pin checks
// ----------
module sdpci_chk
  import sdpci_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic              clock_gate,
  input wire sdpci_cmd_s        cmd_in,
  input wire logic [LANES-1:0]  byte_mask,
  input wire logic [DATA_W-1:0] data_lines_in,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic [LANES-1:0]  data_lines_oe_n,
  input wire logic [BANK_W-1:0] open_banks_0,
  input wire logic [ADDR_W-1:0] mode_reg,
  input wire sdpci_pw_e         power_state,
  input wire logic              buf_stall
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic              tk;
  logic [2:0]        cd;
  logic              ap;
  logic [BANK_W-1:0] bk;
  assign tk = clock_gate & ~cmd_in.chip_select_n;
  assign cd = {cmd_in.row_strobe_n, cmd_in.col_strobe_n,
               cmd_in.write_strobe_n};
  assign ap = cmd_in.row_column_addr_lines[AP_BIT];
  assign bk = cmd_in.bank_select_lines;
  property p_mode;
    tk && cd == 3'h0 |=> mode_reg == $past(cmd_in.row_column_addr_lines);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not loaded");
  property p_act;
    tk && cd == 3'h3 && bk == 2'h0 |=> open_banks_0[0];
  endproperty
  a_act: assert property (p_act) else $error("bank not opened");
  property p_pre_one;
    tk && cd == 3'h2 && !ap && bk == 2'h1 |=> !open_banks_0[1] &&
      open_banks_0[0] == $past(open_banks_0[0]);
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("bank close");
  property p_all;
    tk && cd == 3'h2 && ap |=> open_banks_0 == 2'h0;
  endproperty
  a_all: assert property (p_all) else $error("banks left open");
  property p_cs;
    cmd_in.chip_select_n |=> $stable(mode_reg);
  endproperty
  a_cs: assert property (p_cs) else $error("deselected load");
  property p_gate;
    !clock_gate |=> $stable(mode_reg) && $stable(open_banks_0);
  endproperty
  a_gate: assert property (p_gate) else $error("gated edge used");
  property p_lane;
    data_lines_oe_n != 2'h3 |->
      (~data_lines_oe_n & $past(byte_mask, 3)) == 2'h0;
  endproperty
  a_lane: assert property (p_lane) else $error("masked lane on");
  property p_pw;
    !clock_gate [*2] |-> power_state != SDPCI_PW_RUN;
  endproperty
  a_pw: assert property (p_pw) else $error("still running");
  property p_ap;
    tk && cd == 3'h5 && ap && bk == 2'h0 |-> ##[1:12] !open_banks_0[0];
  endproperty
  a_ap: assert property (p_ap) else $error("no auto close");
endmodule : sdpci_chk

bind sdpci_top sdpci_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_sdpci_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .clock_gate(clock_gate),
  .cmd_in(cmd_in), .byte_mask(byte_mask), .data_lines_in(data_lines_in),
  .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
  .open_banks_0(open_banks_0), .mode_reg(mode_reg),
  .power_state(power_state), .buf_stall(buf_stall)
);

// File: tb/sdpci_ctrl_model.sv
`timescale 1ns/1ps
// ----------------
// Controller model
// ----------------
module sdpci_ctrl_model
  import sdpci_pkg::*;
(
  input  wire logic         ref_clk,
  output logic              clock_gate,
  output sdpci_cmd_s        cmd_in,
  output logic [LANES-1:0]  byte_mask,
  output logic [DATA_W-1:0] data_lines_in
);
  initial begin
    clock_gate    = 1'b1;
    cmd_in        = {1'b1, SDPCI_CMD_NOP, 2'h0, 12'h000};
    byte_mask     = 2'h0;
    data_lines_in = 16'h0000;
  end
  task automatic step();
    @(posedge ref_clk);
    #10;
  endtask : step
  task automatic lines(input logic g, input logic [LANES-1:0] m);
    clock_gate = g;
    byte_mask  = m;
  endtask : lines
  task automatic put(input logic cs_n, input sdpci_cmd_e c,
                     input logic [BANK_W-1:0] b,
                     input logic [ADDR_W-1:0] a);
    cmd_in = {cs_n, c, b, a};
    step();
    cmd_in        = {1'b1, SDPCI_CMD_NOP, ~b, ~a};
    data_lines_in = ~data_lines_in;
  endtask : put
  task automatic wr(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] c,
                    input logic [3:0][DATA_W-1:0] d,
                    input logic [3:0][LANES-1:0] m);
    put(1'b0, SDPCI_CMD_WR, b, {4'h0, c});
    for (int k = 0; k < 4; k++) begin
      data_lines_in = d[k];
      byte_mask     = m[k];
      step();
    end
    data_lines_in = ~data_lines_in;
    byte_mask     = 2'h0;
  endtask : wr
endmodule : sdpci_ctrl_model

// File: tb/sdpci_top_tb.sv
`timescale 1ns/1ps
// -----
// Bench
// -----
module sdpci_top_tb
  import sdpci_pkg::*;
;
  logic                     ref_clk;
  logic                     sys_rst;
  logic                     clock_gate;
  sdpci_cmd_s               cmd_in;
  logic [LANES-1:0]         byte_mask;
  logic [DATA_W-1:0]        data_lines_in;
  logic [DATA_W-1:0]        data_lines_out;
  logic [LANES-1:0]         data_lines_oe_n;
  logic [BANK_W-1:0]        open_banks_0;
  logic [ADDR_W-1:0]        mode_reg;
  sdpci_pw_e                power_state;
  logic                     buf_stall;
  int                       err_total;
  int                       checked;
  int                       cycles;
  logic [ADDR_W-1:0]        op;
  logic [BANK_W-1:0]        bk;
  logic [3:0][DATA_W-1:0]   wd;
  logic [3:0][DATA_W-1:0]   ex;
  sdpci_top i_sdpci_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clock_gate(clock_gate),
    .cmd_in(cmd_in), .byte_mask(byte_mask), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
    .open_banks_0(open_banks_0), .mode_reg(mode_reg),
    .power_state(power_state), .buf_stall(buf_stall)
  );
  sdpci_ctrl_model i_sdpci_ctrl_model (
    .ref_clk(ref_clk), .clock_gate(clock_gate), .cmd_in(cmd_in),
    .byte_mask(byte_mask), .data_lines_in(data_lines_in)
  );
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
      input logic [DATA_W-1:0] n, input logic [LANES-1:0] m);
    merge = o;
    for (int l = 0; l < LANES; l++) begin
      if (!m[l]) merge[l*BYTE_W +: BYTE_W] = n[l*BYTE_W +: BYTE_W];
    end
  endfunction : merge
  task automatic rd(input logic [LANES-1:0] m, input logic ap);
    logic [DATA_W-1:0] on;
    on = {{8{~m[1]}}, {8{~m[0]}}};
    i_sdpci_ctrl_model.lines(1'b1, m);
    i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_RD, bk, {1'b0, ap, 10'h010});
    repeat (3) i_sdpci_ctrl_model.step();
    for (int k = 0; k < 4; k++) begin
      chk("lane enable", 16'(m), 16'(data_lines_oe_n));
      chk("read data", ex[k] & on, data_lines_out & on);
      i_sdpci_ctrl_model.step();
    end
    if (ap && bk < 2) chk("auto close", 16'h0, 16'(open_banks_0[bk]));
  endtask : rd
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    sys_rst   = 1'b1;
    err_total = 0;
    checked   = 0;
    cycles    = 0;
    void'($urandom(78));
    repeat (3) @(posedge ref_clk);
    #10;
    sys_rst = 1'b0;
    op = 12'($urandom());
    i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_MODE, 2'h0, op);
    chk("mode", 16'(op), 16'(mode_reg));
    i_sdpci_ctrl_model.put(1'b1, SDPCI_CMD_MODE, 2'h0, ~op);
    chk("mode", 16'(op), 16'(mode_reg));
    i_sdpci_ctrl_model.lines(1'b0, 2'h0);
    i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_MODE, 2'h0, ~op);
    chk("mode", 16'(op), 16'(mode_reg));
    i_sdpci_ctrl_model.lines(1'b1, 2'h0);
    $display("test mode done");
    i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_ACT, 2'h0, 12'($urandom()));
    i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_ACT, 2'h1, 12'hFFF);
    chk("banks", 16'h3, 16'(open_banks_0));
    i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_PRE, 2'h1, 12'h000);
    chk("banks", 16'h1, 16'(open_banks_0));
    i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_PRE, 2'h3, 12'h400);
    chk("banks", 16'h0, 16'(open_banks_0));
    $display("test banks done");
    for (int i = 0; i < 2; i++) begin
      bk = (i == 0) ? 2'h0 : 2'($urandom());
      i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_ACT, bk, 12'($urandom()));
      for (int k = 0; k < 4; k++) wd[k] = 16'($urandom());
      i_sdpci_ctrl_model.wr(bk, 8'h10, wd, 8'h00);
      ex = wd;
      for (int k = 0; k < 4; k++) wd[k] = 16'($urandom());
      i_sdpci_ctrl_model.wr(bk, 8'h10, wd, 8'hE4);
      for (int k = 0; k < 4; k++) ex[k] = merge(ex[k], wd[k], 2'(k));
      repeat (6) i_sdpci_ctrl_model.step();
      rd(2'h0, 1'b0);
      rd(2'h1, 1'b0);
      rd(2'h2, 1'b1);
      $display("test data done");
    end
    i_sdpci_ctrl_model.lines(1'b0, 2'h0);
    repeat (3) i_sdpci_ctrl_model.step();
    chk("power", 16'(SDPCI_PW_DOWN), 16'(power_state));
    i_sdpci_ctrl_model.lines(1'b1, 2'h0);
    repeat (3) i_sdpci_ctrl_model.step();
    chk("power", 16'(SDPCI_PW_RUN), 16'(power_state));
    i_sdpci_ctrl_model.lines(1'b0, 2'h0);
    i_sdpci_ctrl_model.put(1'b0, SDPCI_CMD_REF, 2'h0, 12'h000);
    repeat (2) i_sdpci_ctrl_model.step();
    chk("power", 16'(SDPCI_PW_SELFREF), 16'(power_state));
    chk("stall", 16'h0, 16'(buf_stall));
    i_sdpci_ctrl_model.lines(1'b1, 2'h0);
    repeat (4) i_sdpci_ctrl_model.step();
    $display("test power done");
    give_verdict();
  end
endmodule : sdpci_top_tb
